// file: flash_port_cfg.svh
// Purpose: Constants for the flash parallel programming port
// Assumes: 100 MHz mclk_i, pins sampled synchronously
// Notes:   Command codes, timing counts, array geometry
`ifndef FLASH_PORT_CFG_SVH
`define FLASH_PORT_CFG_SVH

`define CMD_READ         8'h00
`define CMD_PROGRAM      8'h40
`define CMD_PROG_VERIFY  8'hc0
`define CMD_ERASE        8'h20
`define CMD_ERASE_VERIFY 8'ha0
`define CMD_RESET        8'hff

`define ERASED_BYTE      8'hff
`define CLK_PERIOD_NS    10
`define PROG_TIME_NS     20000
`define ERASE_TIME_NS    20000000
`define PROG_CYCLES      (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define ERASE_CYCLES     (`ERASE_TIME_NS / `CLK_PERIOD_NS)

`define ADDR_W           17
`define BLOCK_ADDR_W     12
`define BOOT_A17         1'b0

`endif

// file: flash_port_pkg.sv
// Purpose: Types for the flash parallel programming port
// Assumes: Included config header
// Notes:   Command modes and the bus pin bundle
package flash_port_pkg;

  typedef enum logic [2:0] {
    MODE_READ         = 3'b000,
    MODE_PROGRAM      = 3'b001,
    MODE_PROG_VERIFY  = 3'b010,
    MODE_ERASE_ARM    = 3'b011,
    MODE_ERASE_VERIFY = 3'b100,
    MODE_RESET_ARM    = 3'b101,
    MODE_IDLE         = 3'b110
  } cmd_mode_t;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_PROG  = 2'b01,
    OP_ERASE = 2'b10
  } op_kind_t;

  typedef struct packed {
    logic       chip_en_n;
    logic       out_en_n;
    logic       write_en_n;
    logic       verify_sel;
    logic       mode_high_voltage_pin;
    logic [3:0] addr_a0_a3;
    logic [3:0] addr_a4_a7;
    logic [7:0] addr_a8_a15;
    logic       addr_a17;
  } bus_pins_t;

  typedef struct packed {
    logic        rd_en;
    logic [17:0] addr;
    logic        wr_en;
    logic [7:0]  wdata;
    logic        erase_en;
    logic        erase_boot;
  } array_req_t;

endpackage

// file: flash_parallel_port.sv
// Purpose: Parallel programming port onto the on-chip flash array
// Assumes: Pins synchronous to mclk_i; array read data valid one cycle after address
// Notes:   Erase and program hold busy for their nominal times or until a second reset command
`include "flash_port_cfg.svh"

module flash_parallel_port #(
  parameter int PROG_CYCLES  = `PROG_CYCLES,
  parameter int ERASE_CYCLES = `ERASE_CYCLES,
  parameter int BLOCK_W      = `BLOCK_ADDR_W
) (
  input  wire logic                       mclk_i,
  input  wire logic                       resetn_i,
  input  wire flash_port_pkg::bus_pins_t  pins_i,
  input  wire logic [7:0]                 data_in_i,
  output logic [7:0]                      data_out_o,
  output logic                            data_oe_o,
  input  wire logic [7:0]                 array_rdata_i,
  input  wire logic                       boot_area_i,
  output flash_port_pkg::array_req_t      array_req_o,
  output logic                            busy_o
);
  import flash_port_pkg::*;

  // ----------------------------------------------------------------
  // Mode and bus state decode
  // ----------------------------------------------------------------
  logic ro_mode;
  logic rw_mode;
  logic rd_state;
  logic wr_state;
  logic [17:0] pin_addr;

  always_comb begin
    ro_mode  = pins_i.mode_high_voltage_pin & ~pins_i.verify_sel;
    rw_mode  = pins_i.mode_high_voltage_pin & pins_i.verify_sel;
    rd_state = (ro_mode | rw_mode) & ~pins_i.chip_en_n & ~pins_i.out_en_n
               & pins_i.write_en_n;
    wr_state = rw_mode & ~pins_i.chip_en_n & pins_i.out_en_n;
    // A16 has no pin and is held at zero
    pin_addr = {pins_i.addr_a17, 1'b0, pins_i.addr_a8_a15,
                pins_i.addr_a4_a7, pins_i.addr_a0_a3};
  end

  // ----------------------------------------------------------------
  // Write-enable edge detection and capture
  // ----------------------------------------------------------------
  logic        we_n_r;
  logic        we_n_nxt;
  logic        armed_r;
  logic        armed_nxt;
  logic [17:0] addr_r;
  logic [17:0] addr_nxt;
  logic        we_fall;
  logic        we_rise;

  always_comb begin
    we_n_nxt  = pins_i.write_en_n;
    we_fall   = we_n_r & ~pins_i.write_en_n;
    we_rise   = ~we_n_r & pins_i.write_en_n;
    armed_nxt = armed_r;
    addr_nxt  = addr_r;
    if (we_fall) begin
      armed_nxt = wr_state;
      if (wr_state) begin
        addr_nxt = pin_addr;
      end
    end else if (we_rise) begin
      armed_nxt = 1'b0;
    end else if (!wr_state) begin
      armed_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      we_n_r  <= 1'b1;
      armed_r <= 1'b0;
      addr_r  <= '0;
    end else begin
      we_n_r  <= we_n_nxt;
      armed_r <= armed_nxt;
      addr_r  <= addr_nxt;
    end
  end

  logic       cmd_strobe;
  logic [7:0] cmd_byte;

  always_comb begin
    cmd_strobe = we_rise & armed_r & wr_state;
    cmd_byte   = data_in_i;
  end

  // ----------------------------------------------------------------
  // Command decode and operation sequencing
  // ----------------------------------------------------------------
  cmd_mode_t   mode_r;
  cmd_mode_t   mode_nxt;
  op_kind_t    op_r;
  op_kind_t    op_nxt;
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  array_req_t  req_r;
  array_req_t  req_nxt;

  always_comb begin
    mode_nxt     = mode_r;
    op_nxt       = op_r;
    busy_cnt_nxt = busy_cnt_r;
    req_nxt      = '0;
    req_nxt.addr = req_r.addr;
    // Show the captured write address so the array can flag the boot area
    if (we_fall && wr_state) begin
      req_nxt.addr = pin_addr;
    end
    if (op_r != OP_NONE) begin
      if (busy_cnt_r == 32'h0000_0001) begin
        op_nxt   = OP_NONE;
        mode_nxt = MODE_IDLE;
      end
      busy_cnt_nxt = busy_cnt_r - 32'h0000_0001;
    end
    if (cmd_strobe) begin
      unique case (mode_r)
        MODE_PROGRAM: begin
          if (op_r == OP_NONE) begin
            req_nxt.wr_en = 1'b1;
            req_nxt.addr  = addr_r;
            req_nxt.wdata = cmd_byte;
            op_nxt        = OP_PROG;
            busy_cnt_nxt  = 32'(PROG_CYCLES);
            mode_nxt      = MODE_PROGRAM;
          end else if (cmd_byte == `CMD_RESET) begin
            mode_nxt = MODE_RESET_ARM;
          end
        end
        MODE_ERASE_ARM: begin
          if (cmd_byte == `CMD_ERASE) begin
            req_nxt.erase_en   = 1'b1;
            req_nxt.erase_boot = boot_area_i;
            req_nxt.addr       = boot_area_i ?
              {addr_r[17:BLOCK_W], {BLOCK_W{1'b0}}} : addr_r;
            op_nxt       = OP_ERASE;
            busy_cnt_nxt = 32'(ERASE_CYCLES);
            mode_nxt     = MODE_IDLE;
          end else begin
            mode_nxt = MODE_IDLE;
          end
        end
        MODE_RESET_ARM: begin
          if (cmd_byte == `CMD_RESET) begin
            op_nxt       = OP_NONE;
            busy_cnt_nxt = '0;
            mode_nxt     = MODE_READ;
          end else begin
            mode_nxt = MODE_IDLE;
          end
        end
        default: begin
          if (op_r != OP_NONE) begin
            if (cmd_byte == `CMD_RESET) begin
              mode_nxt = MODE_RESET_ARM;
            end
          end else begin
            unique case (cmd_byte)
              `CMD_READ:         mode_nxt = MODE_READ;
              `CMD_PROGRAM:      mode_nxt = MODE_PROGRAM;
              `CMD_PROG_VERIFY:  mode_nxt = MODE_PROG_VERIFY;
              `CMD_ERASE:        mode_nxt = MODE_ERASE_ARM;
              `CMD_ERASE_VERIFY: mode_nxt = MODE_ERASE_VERIFY;
              `CMD_RESET:        mode_nxt = MODE_RESET_ARM;
              default:           mode_nxt = MODE_IDLE;
            endcase
          end
        end
      endcase
    end
    if (rd_state && op_r == OP_NONE && req_nxt.wr_en == 1'b0 &&
        req_nxt.erase_en == 1'b0) begin
      req_nxt.rd_en = 1'b1;
      req_nxt.addr  = pin_addr;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      mode_r     <= MODE_READ;
      op_r       <= OP_NONE;
      busy_cnt_r <= '0;
      req_r      <= '0;
    end else begin
      mode_r     <= mode_nxt;
      op_r       <= op_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      req_r      <= req_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Data pin drive
  // ----------------------------------------------------------------
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic       busy_r;
  logic       busy_nxt;

  always_comb begin
    // Array data only in read or verify modes; no identification code
    unique case (mode_r)
      MODE_READ,
      MODE_PROG_VERIFY,
      MODE_ERASE_VERIFY: dout_nxt = array_rdata_i;
      default:           dout_nxt = '0;
    endcase
    // Release on standby, output disable and write enable low
    oe_nxt   = rd_state & pins_i.write_en_n;
    busy_nxt = (op_nxt != OP_NONE);
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      dout_r <= '0;
      oe_r   <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      oe_r   <= oe_nxt;
      busy_r <= busy_nxt;
    end
  end

  always_comb begin
    data_out_o  = dout_r;
    data_oe_o   = oe_r;
    array_req_o = req_r;
    busy_o      = busy_r;
  end

endmodule

// file: flash_port_checker.sv
// Purpose: Port assertions for the flash programming port
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached to the design by bind
module flash_port_checker
  import flash_port_pkg::*;
(
  input wire logic                      mclk_i,
  input wire logic                      resetn_i,
  input wire flash_port_pkg::bus_pins_t pins_i,
  input wire logic [7:0]                data_in_i,
  input wire logic [7:0]                data_out_o,
  input wire logic                      data_oe_o,
  input wire logic [7:0]                array_rdata_i,
  input wire logic                      boot_area_i,
  input wire flash_port_pkg::array_req_t array_req_o,
  input wire logic                      busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_st;
  logic req_any;
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  assign rd_st = !pins_i.chip_en_n && !pins_i.out_en_n && pins_i.write_en_n && pins_i.mode_high_voltage_pin;
  assign req_any = array_req_o.wr_en || array_req_o.erase_en;

  chk_read_drive: assert property (rd_st |=> data_oe_o)
    else $error("data pins not driven in read state");
  chk_odis_hiz: assert property (!pins_i.chip_en_n && pins_i.out_en_n && pins_i.write_en_n |=> !data_oe_o)
    else $error("data pins driven with output disabled");
  chk_standby_hiz: assert property (pins_i.chip_en_n |=> !data_oe_o)
    else $error("data pins driven in standby");
  chk_we_no_drive: assert property (!pins_i.write_en_n |=> !data_oe_o)
    else $error("data pins driven while write enable low");
  chk_ro_no_write: assert property (!pins_i.verify_sel |=> !req_any)
    else $error("write accepted in read-only mode");
  chk_ce_no_latch: assert property (pins_i.chip_en_n |=> !req_any)
    else $error("write accepted in standby");
  chk_rise_capture: assert property ($rose(req_any) |-> $past(pins_i.write_en_n) && !$past(pins_i.write_en_n, 2))
    else $error("request not tied to write enable rising");
  chk_busy_start: assert property (req_any |-> busy_o)
    else $error("operation started without busy");
  chk_boot_block: assert property (array_req_o.erase_en && array_req_o.erase_boot |-> array_req_o.addr[11:0] == 12'h000)
    else $error("boot erase not block aligned");
  chk_addr_map: assert property (array_req_o.addr[16] == 1'b0)
    else $error("array address bit 16 set");
  chk_addr_a17: assert property (array_req_o.rd_en |-> array_req_o.addr[17] == $past(pins_i.addr_a17))
    else $error("address bit 17 not taken from its pin");

  cover property (array_req_o.wr_en);
  cover property (array_req_o.erase_en && array_req_o.erase_boot);
  cover property (rd_st ##1 data_oe_o);
endmodule

bind flash_parallel_port flash_port_checker flash_port_checker_inst (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .pins_i(pins_i), .data_in_i(data_in_i), .data_out_o(data_out_o),
  .data_oe_o(data_oe_o), .array_rdata_i(array_rdata_i), .boot_area_i(boot_area_i),
  .array_req_o(array_req_o), .busy_o(busy_o)
);

// file: flash_array_model.sv
// Purpose: Behavioural flash array behind the port
// Assumes: Read byte registered from the prior cycle address
// Notes:   Only 256 bytes kept; erase clears them all
module flash_array_model
  import flash_port_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire flash_port_pkg::array_req_t req_i,
  output logic [7:0]                      rdata_o,
  output logic                            boot_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  // ----------------------------------------
  // Array storage
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  assign boot_o = (req_i.addr[15:12] == 4'hf);
  always @(posedge mclk_i) begin
    rdata_o <= mem[req_i.addr[7:0]];
    if (req_i.wr_en) mem[req_i.addr[7:0]] <= req_i.wdata;
    if (req_i.erase_en) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'hff;
    end
  end
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for the flash programming port
// Assumes: Inputs driven at the falling clock edge
// Notes:   Shortened program and erase times
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_port_pkg::*;
  localparam int PROG_N  = 12;
  localparam int ERASE_N = 20;
  logic       mclk_i   = 1'b0;
  logic       resetn_i = 1'b0;
  bus_pins_t  pins     = 21'h1c0000;
  logic [7:0] data_in  = 8'h00;
  logic [7:0] data_out;
  logic [7:0] rdata;
  logic       data_oe;
  logic       boot;
  logic       busy;
  array_req_t req;
  int         err_count = 0;
  int         checked   = 0;
  int         cycles    = 0;
  int         seed      = 32'h3eafbaf2;
  logic [15:0] a;
  logic [7:0]  d;
  // ----------------------------------------
  // Design, array and helpers
  // ----------------------------------------
  always #5 mclk_i = ~mclk_i;

  flash_parallel_port #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N), .BLOCK_W(12)) flash_parallel_port_inst (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .pins_i(pins), .data_in_i(data_in), .data_out_o(data_out),
    .data_oe_o(data_oe), .array_rdata_i(rdata), .boot_area_i(boot), .array_req_o(req), .busy_o(busy));
  flash_array_model flash_array_model_inst (.mclk_i(mclk_i), .req_i(req), .rdata_o(rdata), .boot_o(boot));

  function automatic bus_pins_t mk(input logic ce, input logic oe, input logic we, input logic vs,
                                   input logic [15:0] ad);
    return {ce, oe, we, vs, 1'b1, ad[3:0], ad[7:4], ad[15:8], 1'b0};
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Counts: checked=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] dv, input logic vs, input logic ce_n);
    @(negedge mclk_i);
    pins = mk(ce_n, 1'b1, 1'b0, vs, ad);
    data_in = dv;
    @(negedge mclk_i);
    pins.write_en_n = 1'b1;
    @(negedge mclk_i);
    pins.chip_en_n = 1'b1;
  endtask

  task automatic rd(input logic [15:0] ad, input logic [7:0] exp);
    @(negedge mclk_i);
    pins = mk(1'b0, 1'b0, 1'b1, 1'b1, ad);
    repeat (3) @(negedge mclk_i);
    cmp({15'h0, data_oe}, 16'h0001);
    cmp({8'h00, data_out}, {8'h00, exp});
    cmp(req.addr[15:0], ad);
    pins.chip_en_n = 1'b1;
    @(negedge mclk_i);
    cmp({15'h0, data_oe}, 16'h0000);
  endtask

  task automatic busy_len(input int exp);
    int n;
    n = 0;
    repeat (30) begin
      if (busy === 1'b1) n++;
      @(negedge mclk_i);
    end
    cmp(16'(n), 16'(exp));
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge mclk_i);
    resetn_i = 1'b1;
    rd(16'h0012, 8'h48);
    @(negedge mclk_i);
    pins = mk(1'b0, 1'b0, 1'b1, 1'b1, 16'h0012) | 21'h000001;
    repeat (2) @(negedge mclk_i);
    cmp({14'h0, req.addr[17:16]}, 16'h0002);
    pins.chip_en_n = 1'b1;
    repeat (4) begin
      a = 16'($random(seed));
      d = 8'($random(seed));
      wr(16'h0000, 8'h40, 1'b1, 1'b0);
      wr(a, d, 1'b1, 1'b0);
      busy_len(PROG_N);
      wr(16'h0000, 8'hc0, 1'b1, 1'b0);
      rd(a, d);
    end
    wr(16'h0000, 8'h40, 1'b0, 1'b0);
    wr(a, ~d, 1'b0, 1'b0);
    wr(16'h0000, 8'h40, 1'b1, 1'b1);
    wr(a, ~d, 1'b1, 1'b1);
    busy_len(0);
    rd(a, d);
    wr(16'h0000, 8'h40, 1'b1, 1'b0);
    wr(a, 8'h3c, 1'b1, 1'b0);
    wr(16'h0000, 8'hff, 1'b1, 1'b0);
    wr(16'h0000, 8'hff, 1'b1, 1'b0);
    cmp({15'h0, busy}, 16'h0000);
    rd(a, 8'h3c);
    wr(16'h0000, 8'h20, 1'b1, 1'b0);
    wr(16'h0000, 8'h55, 1'b1, 1'b0);
    cmp({15'h0, busy}, 16'h0000);
    wr(16'h0000, 8'h55, 1'b1, 1'b0);
    rd(a, 8'h00);
    wr(16'h0000, 8'h00, 1'b1, 1'b0);
    rd(a, 8'h3c);
    wr(16'hf000, 8'h20, 1'b1, 1'b0);
    wr(16'hf000, 8'h20, 1'b1, 1'b0);
    busy_len(ERASE_N);
    wr(16'h0000, 8'ha0, 1'b1, 1'b0);
    rd(a, 8'hff);
    stop_test();
  end
endmodule
